// file: logic/mpio_consts.vh
`ifndef MPIO_CONSTS_VH
`define MPIO_CONSTS_VH

// ----------------------------------------------------------------
// register bus geometry
// ----------------------------------------------------------------
`define MPIO_AW 8
`define MPIO_DW 8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MPIO_OFS_P0_DATA 8'he0
`define MPIO_OFS_P1_DATA 8'he1
`define MPIO_OFS_P2_DATA 8'he2
`define MPIO_OFS_P3_DATA 8'he3
`define MPIO_OFS_P0_HCFG 8'he4
`define MPIO_OFS_P0_LCFG 8'he5
`define MPIO_OFS_P1_CFG 8'he6
`define MPIO_OFS_P2_HCFG 8'he7
`define MPIO_OFS_P2_LCFG 8'he8
`define MPIO_OFS_P3_HCFG 8'he9
`define MPIO_OFS_P3_LCFG 8'hea
`define MPIO_OFS_IRQ 8'heb

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MPIO_DATA_RST 8'h00
`define MPIO_P1_DATA_RST 3'h0
`define MPIO_CFG_RST 8'h00
`define MPIO_IRQ_RST 3'h0
`define MPIO_RD_ZERO 8'h00

// ----------------------------------------------------------------
// field layout of the interrupt register
// ----------------------------------------------------------------
`define MPIO_IRQ_EN_LSB 0
`define MPIO_IRQ_EN_MSB 2
`define MPIO_IRQ_PND_LSB 4
`define MPIO_IRQ_PND_MSB 6
`define MPIO_P1_W 3

// ----------------------------------------------------------------
// pin assignments of alternate functions
// ----------------------------------------------------------------
`define MPIO_CAP_PIN 4
`define MPIO_CAP_FLD 2'h0
`define MPIO_SB_NPINS 2

// ----------------------------------------------------------------
// configuration field codes
// ----------------------------------------------------------------
`define MPIO_P0L_IN 2'h0
`define MPIO_P0L_RISE 2'h1
`define MPIO_P0L_FALL 2'h2
`define MPIO_P0L_PP 2'h3
`define MPIO_P0H_ALT 2'h1
`define MPIO_P1_IN 2'h0
`define MPIO_P1_PP 2'h1
`define MPIO_P1_OD 2'h2
`define MPIO_P1_ALT 2'h3
`define MPIO_P2H_PP 2'h1
`define MPIO_P2H_PWM 2'h2
`define MPIO_P2H_PWMOD 2'h3
`define MPIO_P2L_PP 2'h2
`define MPIO_P2L_PWM 2'h3
`define MPIO_P3H_PULL 2'h1
`define MPIO_P3L_ANA 2'h1
`define MPIO_P3_PP 2'h2
`define MPIO_P3_OD 2'h3

`endif

// file: logic/mpio_pin_drv.v
`timescale 1ns/10ps

// ----------------------------------------------------------------
// pin driver: turns per-pin drive style into out, enable, readback
// ----------------------------------------------------------------
module mpio_pin_drv #(
  parameter W = 8
) (
  input wire [W-1:0] val_i,
  input wire [W-1:0] pp_i,
  input wire [W-1:0] od_i,
  input wire [W-1:0] pin_i,
  output wire [W-1:0] out_o,
  output wire [W-1:0] oe_o,
  output wire [W-1:0] rd_o
);

  // open drain only ever pulls low, so its out level is zero
  assign out_o = val_i & pp_i;
  assign oe_o = pp_i | (od_i & ~val_i);

  // push-pull pins read their driven value, all others read the pad
  assign rd_o = (pp_i & val_i) | (~pp_i & pin_i);

endmodule

// file: logic/mpio_edge_det.v
`timescale 1ns/10ps

// ----------------------------------------------------------------
// edge detector for the external interrupt pins
// ----------------------------------------------------------------
module mpio_edge_det #(
  parameter W = 3
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [W-1:0] level_i,
  input wire [W-1:0] rise_sel_i,
  input wire [W-1:0] arm_i,
  output wire [W-1:0] hit_o
);

  reg [W-1:0] prev;
  reg primed;

  // history of the pin; the first cycle after reset only samples
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev <= {W{1'b0}};
      primed <= 1'b0;
    end else begin
      prev <= level_i;
      primed <= 1'b1;
    end
  end

  // one-cycle pulse on the selected edge of an armed pin
  assign hit_o = {W{primed}} & arm_i &
    ((rise_sel_i & level_i & ~prev) | (~rise_sel_i & ~level_i & prev));

endmodule

// file: logic/mpio_port_io.v
`timescale 1ns/10ps
`include "mpio_consts.vh"


module mpio_port_io (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [`MPIO_AW-1:0] addr_i,
  input wire [`MPIO_DW-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`MPIO_DW-1:0] rdata_o,
  input wire [7:0] p0_in_i,
  output wire [7:0] p0_out_o,
  output wire [7:0] p0_oe_o,
  input wire [`MPIO_P1_W-1:0] p1_in_i,
  output wire [`MPIO_P1_W-1:0] p1_out_o,
  output wire [`MPIO_P1_W-1:0] p1_oe_o,
  input wire [7:0] p2_in_i,
  output wire [7:0] p2_out_o,
  output wire [7:0] p2_oe_o,
  input wire [7:0] p3_in_i,
  output wire [7:0] p3_out_o,
  output wire [7:0] p3_oe_o,
  output reg [3:0] p3_pullup_o,
  output reg [3:0] analog_in_sel_o,
  input wire [6:0] pwm_i,
  input wire sb_clk_low_i,
  input wire sb_dat_low_i,
  output wire serial_bus_clock_pin_o,
  output wire serial_bus_data_pin_o,
  output wire timer_capture_pin_o,
  output wire [2:0] ext_irq_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // picks the two-bit field of one pin out of a config byte
  function [1:0] fld;
    input [7:0] cfg;
    input [1:0] k;
    reg [7:0] sh;
    begin
      sh = cfg >> {k, 1'b0};
      fld = sh[1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [7:0] port_zero_data, port_two_data, port_three_data;
  reg [`MPIO_P1_W-1:0] port_one_data;
  reg [7:0] port_zero_hi_cfg, port_zero_lo_cfg, port_one_cfg;
  reg [7:0] port_two_hi_cfg, port_two_lo_cfg;
  reg [7:0] port_three_hi_cfg, port_three_lo_cfg;
  reg [2:0] irq_enable, irq_pending, next_irq_pending;
  reg [`MPIO_DW-1:0] next_rdata;

  // per-pin drive style, driven value and interrupt setup
  reg [7:0] pp0, pp2, od2, val2, pp3, od3;
  reg [`MPIO_P1_W-1:0] pp1, od1, val1;
  reg [2:0] irq_pin_on, irq_rise;
  reg [1:0] sb_alt, fl0, fh0, fl1, fl2, fh2, fl3, fh3;
  integer i0, i1, i2, i3;

  wire [7:0] rd0, rd2, rd3;
  wire [`MPIO_P1_W-1:0] rd1;
  wire [2:0] edge_hit;
  wire [1:0] sb_low;
  wire wr_irq;

  assign sb_low = {sb_clk_low_i, sb_dat_low_i};
  assign wr_irq = wr_i && (addr_i == `MPIO_OFS_IRQ);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------

  // data and config registers; plain stores, no side effects
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_zero_data <= `MPIO_DATA_RST;
      port_one_data <= `MPIO_P1_DATA_RST;
      port_two_data <= `MPIO_DATA_RST;
      port_three_data <= `MPIO_DATA_RST;
      port_zero_hi_cfg <= `MPIO_CFG_RST;
      port_zero_lo_cfg <= `MPIO_CFG_RST;
      port_one_cfg <= `MPIO_CFG_RST;
      port_two_hi_cfg <= `MPIO_CFG_RST;
      port_two_lo_cfg <= `MPIO_CFG_RST;
      port_three_hi_cfg <= `MPIO_CFG_RST;
      port_three_lo_cfg <= `MPIO_CFG_RST;
      irq_enable <= `MPIO_IRQ_RST;
    end else if (wr_i) begin
      case (addr_i)
        `MPIO_OFS_P0_DATA: port_zero_data <= wdata_i;
        `MPIO_OFS_P1_DATA: port_one_data <= wdata_i[`MPIO_P1_W-1:0];
        `MPIO_OFS_P2_DATA: port_two_data <= wdata_i;
        `MPIO_OFS_P3_DATA: port_three_data <= wdata_i;
        `MPIO_OFS_P0_HCFG: port_zero_hi_cfg <= wdata_i;
        `MPIO_OFS_P0_LCFG: port_zero_lo_cfg <= wdata_i;
        `MPIO_OFS_P1_CFG: port_one_cfg <= wdata_i;
        `MPIO_OFS_P2_HCFG: port_two_hi_cfg <= wdata_i;
        `MPIO_OFS_P2_LCFG: port_two_lo_cfg <= wdata_i;
        `MPIO_OFS_P3_HCFG: port_three_hi_cfg <= wdata_i;
        `MPIO_OFS_P3_LCFG: port_three_lo_cfg <= wdata_i;
        `MPIO_OFS_IRQ: begin
          irq_enable <= wdata_i[`MPIO_IRQ_EN_MSB:`MPIO_IRQ_EN_LSB];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // port 0 decode
  // ----------------------------------------------------------------

  // low fields: in, rising irq, falling irq, push-pull;
  // high fields: bit 1 set means push-pull output
  always @* begin
    pp0 = 8'h00;
    irq_pin_on = 3'h0;
    irq_rise = 3'h0;
    fl0 = 2'h0;
    fh0 = 2'h0;
    for (i0 = 0; i0 < 4; i0 = i0 + 1) begin
      fl0 = fld(port_zero_lo_cfg, i0[1:0]);
      fh0 = fld(port_zero_hi_cfg, i0[1:0]);
      pp0[i0] = (fl0 == `MPIO_P0L_PP);
      pp0[i0 + 4] = fh0[1];
      if (i0 < 3) begin
        irq_pin_on[i0] = (fl0 == `MPIO_P0L_RISE) ||
          (fl0 == `MPIO_P0L_FALL);
        irq_rise[i0] = (fl0 == `MPIO_P0L_RISE);
      end
    end
  end

  // capture input follows pin 4 only while its field selects it
  assign timer_capture_pin_o =
    (fld(port_zero_hi_cfg, `MPIO_CAP_FLD) == `MPIO_P0H_ALT) &&
    p0_in_i[`MPIO_CAP_PIN];

  // ----------------------------------------------------------------
  // port 1 decode
  // ----------------------------------------------------------------

  // serial function is open drain; the bus unit asks for a low
  always @* begin
    pp1 = {`MPIO_P1_W{1'b0}};
    od1 = {`MPIO_P1_W{1'b0}};
    val1 = port_one_data;
    sb_alt = 2'h0;
    fl1 = 2'h0;
    for (i1 = 0; i1 < `MPIO_P1_W; i1 = i1 + 1) begin
      fl1 = fld(port_one_cfg, i1[1:0]);
      pp1[i1] = (fl1 == `MPIO_P1_PP);
      od1[i1] = (fl1 == `MPIO_P1_OD);
      if (i1 < `MPIO_SB_NPINS && fl1 == `MPIO_P1_ALT) begin
        sb_alt[i1] = 1'b1;
        od1[i1] = 1'b1;
        val1[i1] = ~sb_low[i1];
      end
    end
  end

  // bus unit sees the pad level, idle high when not routed
  assign serial_bus_clock_pin_o = ~sb_alt[1] | p1_in_i[1];
  assign serial_bus_data_pin_o = ~sb_alt[0] | p1_in_i[0];

  // ----------------------------------------------------------------
  // port 2 decode
  // ----------------------------------------------------------------

  // pins 3..0 from the low register, 7..4 from the high one;
  // pin 7 has no pwm source and only knows push-pull
  always @* begin
    pp2 = 8'h00;
    od2 = 8'h00;
    val2 = port_two_data;
    fl2 = 2'h0;
    fh2 = 2'h0;
    for (i2 = 0; i2 < 4; i2 = i2 + 1) begin
      fl2 = fld(port_two_lo_cfg, i2[1:0]);
      fh2 = fld(port_two_hi_cfg, i2[1:0]);
      pp2[i2] = fl2[1];
      if (fl2 == `MPIO_P2L_PWM) val2[i2] = pwm_i[i2];
      if (i2 < 3) begin
        pp2[i2 + 4] = (fh2 == `MPIO_P2H_PP) ||
          (fh2 == `MPIO_P2H_PWM);
        od2[i2 + 4] = (fh2 == `MPIO_P2H_PWMOD);
        if (fh2[1]) val2[i2 + 4] = pwm_i[i2 + 4];
      end else begin
        pp2[i2 + 4] = (fh2 == `MPIO_P2H_PP);
      end
    end
  end

  // ----------------------------------------------------------------
  // port 3 decode
  // ----------------------------------------------------------------

  // high: in, in with pull-up, pp, od; low: in, analog, pp, od
  always @* begin
    pp3 = 8'h00;
    od3 = 8'h00;
    p3_pullup_o = 4'h0;
    analog_in_sel_o = 4'h0;
    fl3 = 2'h0;
    fh3 = 2'h0;
    for (i3 = 0; i3 < 4; i3 = i3 + 1) begin
      fl3 = fld(port_three_lo_cfg, i3[1:0]);
      fh3 = fld(port_three_hi_cfg, i3[1:0]);
      pp3[i3 + 4] = (fh3 == `MPIO_P3_PP);
      od3[i3 + 4] = (fh3 == `MPIO_P3_OD);
      p3_pullup_o[i3] = (fh3 == `MPIO_P3H_PULL);
      pp3[i3] = (fl3 == `MPIO_P3_PP);
      od3[i3] = (fl3 == `MPIO_P3_OD);
      analog_in_sel_o[i3] = (fl3 == `MPIO_P3L_ANA);
    end
  end

  // ----------------------------------------------------------------
  // pad drivers
  // ----------------------------------------------------------------

  // port 0 has no open-drain mode
  mpio_pin_drv #(.W(8)) u_drv0 (
    .val_i(port_zero_data),
    .pp_i(pp0),
    .od_i(8'h00),
    .pin_i(p0_in_i),
    .out_o(p0_out_o),
    .oe_o(p0_oe_o),
    .rd_o(rd0)
  );

  mpio_pin_drv #(.W(`MPIO_P1_W)) u_drv1 (
    .val_i(val1),
    .pp_i(pp1),
    .od_i(od1),
    .pin_i(p1_in_i),
    .out_o(p1_out_o),
    .oe_o(p1_oe_o),
    .rd_o(rd1)
  );

  mpio_pin_drv #(.W(8)) u_drv2 (
    .val_i(val2),
    .pp_i(pp2),
    .od_i(od2),
    .pin_i(p2_in_i),
    .out_o(p2_out_o),
    .oe_o(p2_oe_o),
    .rd_o(rd2)
  );

  mpio_pin_drv #(.W(8)) u_drv3 (
    .val_i(port_three_data),
    .pp_i(pp3),
    .od_i(od3),
    .pin_i(p3_in_i),
    .out_o(p3_out_o),
    .oe_o(p3_oe_o),
    .rd_o(rd3)
  );

  // ----------------------------------------------------------------
  // external interrupts
  // ----------------------------------------------------------------

  // only enabled lines on interrupt-configured pins are armed
  mpio_edge_det #(.W(3)) u_edge (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .level_i(p0_in_i[2:0]),
    .rise_sel_i(irq_rise),
    .arm_i(irq_pin_on & irq_enable),
    .hit_o(edge_hit)
  );

  // a write of zero clears, one keeps; a new edge beats the clear
  always @* begin
    next_irq_pending = irq_pending;
    if (wr_irq) begin
      next_irq_pending = irq_pending &
        wdata_i[`MPIO_IRQ_PND_MSB:`MPIO_IRQ_PND_LSB];
    end
    next_irq_pending = next_irq_pending | edge_hit;
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_pending <= `MPIO_IRQ_RST;
    end else begin
      irq_pending <= next_irq_pending;
    end
  end

  // request stands while pending and still enabled
  assign ext_irq_o = irq_pending & irq_enable;

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------

  // unmapped offsets and unused bits read as zero
  always @* begin
    next_rdata = `MPIO_RD_ZERO;
    case (addr_i)
      `MPIO_OFS_P0_DATA: next_rdata = rd0;
      `MPIO_OFS_P1_DATA: next_rdata[`MPIO_P1_W-1:0] = rd1;
      `MPIO_OFS_P2_DATA: next_rdata = rd2;
      `MPIO_OFS_P3_DATA: next_rdata = rd3;
      `MPIO_OFS_P0_HCFG: next_rdata = port_zero_hi_cfg;
      `MPIO_OFS_P0_LCFG: next_rdata = port_zero_lo_cfg;
      `MPIO_OFS_P1_CFG: next_rdata = port_one_cfg;
      `MPIO_OFS_P2_HCFG: next_rdata = port_two_hi_cfg;
      `MPIO_OFS_P2_LCFG: next_rdata = port_two_lo_cfg;
      `MPIO_OFS_P3_HCFG: next_rdata = port_three_hi_cfg;
      `MPIO_OFS_P3_LCFG: next_rdata = port_three_lo_cfg;
      `MPIO_OFS_IRQ: begin
        next_rdata[`MPIO_IRQ_EN_MSB:`MPIO_IRQ_EN_LSB] = irq_enable;
        next_rdata[`MPIO_IRQ_PND_MSB:`MPIO_IRQ_PND_LSB] =
          irq_pending;
      end
      default: next_rdata = `MPIO_RD_ZERO;
    endcase
  end

  // read data stand for the single cycle after the strobe
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `MPIO_RD_ZERO;
    end else begin
      rdata_o <= rd_i ? next_rdata : `MPIO_RD_ZERO;
    end
  end

endmodule

// file: dv/mpio_pad_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// board side of the pins
// ----------------------------------------------------------------
module mpio_pad_model #(
  parameter W = 8
) (
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] ext_i,
  output logic [W-1:0] pad_o
);
  // device level wins where enabled, else the outside source
  assign pad_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// file: dv/mpio_port_io_props.sv
`timescale 1ns/10ps
`include "mpio_consts.vh"

// ----------------------------------------------------------------
// checker on the port block pins
// ----------------------------------------------------------------
module mpio_port_io_chk (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] p0_in_i,
  input wire logic [2:0] p1_in_i,
  input wire logic serial_bus_clock_pin_o,
  input wire logic timer_capture_pin_o,
  input wire logic [2:0] ext_irq_o
);
  logic [7:0] p0l, p0h, p1c;
  logic [2:0] en;
  logic [1:0] warm;

  // shadow of the configuration written over the bus
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p0l <= 8'h00;
      p0h <= 8'h00;
      p1c <= 8'h00;
      en <= 3'h0;
      warm <= 2'h0;
    end else begin
      if (warm != 2'h3) warm <= warm + 2'h1;
      if (wr_i && addr_i == `MPIO_OFS_P0_LCFG) p0l <= wdata_i;
      if (wr_i && addr_i == `MPIO_OFS_P0_HCFG) p0h <= wdata_i;
      if (wr_i && addr_i == `MPIO_OFS_P1_CFG) p1c <= wdata_i;
      if (wr_i && addr_i == `MPIO_OFS_IRQ) en <= wdata_i[2:0];
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cfg_wr;
    wr_i && addr_i >= `MPIO_OFS_P0_HCFG && addr_i <= `MPIO_OFS_P3_LCFG;
  endsequence
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  sequence s_rise0;
    warm == 2'h3 && en[0] && p0l[1:0] == 2'h1 && !p0_in_i[0]
      ##1 en[0] && p0l[1:0] == 2'h1 && p0_in_i[0];
  endsequence
  sequence s_fall1;
    warm == 2'h3 && en[1] && p0l[3:2] == 2'h2 && p0_in_i[1]
      ##1 en[1] && p0l[3:2] == 2'h2 && !p0_in_i[1];
  endsequence

  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  property p_cfg_rw;
    s_cfg_wr ##2 (rd_i && addr_i == $past(addr_i, 2))
      |=> rdata_o == $past(wdata_i, 3);
  endproperty
  property p_p1_rd;
    s_rd(`MPIO_OFS_P1_DATA) |=> rdata_o[7:3] == 5'h00;
  endproperty
  property p_irq_rd;
    s_rd(`MPIO_OFS_IRQ)
      |=> !rdata_o[7] && !rdata_o[3] && rdata_o[2:0] == $past(en);
  endproperty
  property p_unmap;
    s_rd(8'h10) |=> rdata_o == 8'h00;
  endproperty
  property p_irq_hold;
    ext_irq_o[0] && !(wr_i && addr_i == `MPIO_OFS_IRQ) |=> ext_irq_o[0];
  endproperty
  property p_rise0;
    s_rise0 |-> ##[1:2] ext_irq_o[0];
  endproperty
  property p_fall1;
    s_fall1 |-> ##[1:2] ext_irq_o[1];
  endproperty
  property p_sb_clk;
    serial_bus_clock_pin_o == (p1c[3:2] == 2'h3 ? p1_in_i[1] : 1'b1);
  endproperty
  property p_cap;
    timer_capture_pin_o == (p0h[1:0] == 2'h1 ? p0_in_i[4] : 1'b0);
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_cfg_rw: assert property (p_cfg_rw)
    else $error("config readback wrong");
  a_p1_rd: assert property (p_p1_rd)
    else $error("port one upper bits set");
  a_irq_rd: assert property (p_irq_rd)
    else $error("irq register readback wrong");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq request dropped");
  a_rise0: assert property (p_rise0)
    else $error("rising edge missed");
  a_fall1: assert property (p_fall1)
    else $error("falling edge missed");
  a_sb_clk: assert property (p_sb_clk)
    else $error("serial clock routing wrong");
  a_cap: assert property (p_cap)
    else $error("capture routing wrong");
endmodule

bind mpio_port_io mpio_port_io_chk u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .p0_in_i(p0_in_i), .p1_in_i(p1_in_i), .ext_irq_o(ext_irq_o),
  .serial_bus_clock_pin_o(serial_bus_clock_pin_o),
  .timer_capture_pin_o(timer_capture_pin_o)
);

// file: dv/mpio_port_io_test.sv
`timescale 1ns/10ps
`include "mpio_consts.vh"

module mpio_port_io_test;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [6:0] pwm_i = 7'h00;
  logic sb_clk_low_i = 1'b0;
  logic sb_dat_low_i = 1'b0;
  logic [7:0] ext0 = 8'h00, ext2 = 8'hff, ext3 = 8'hff;
  logic [2:0] ext1 = 3'h7;
  wire [7:0] rdata_o, p0_in_i, p0_out_o, p0_oe_o, p2_in_i, p2_out_o;
  wire [7:0] p2_oe_o, p3_in_i, p3_out_o, p3_oe_o;
  wire [2:0] p1_in_i, p1_out_o, p1_oe_o, ext_irq_o;
  wire [3:0] p3_pullup_o, analog_in_sel_o;
  wire serial_bus_clock_pin_o, serial_bus_data_pin_o, timer_capture_pin_o;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'heba4;
  logic [7:0] v, d, m, cf;
  logic [15:0] e, s;
  int k1[4] = '{0, 1, 2, 0};
  int k2l[4] = '{0, 0, 1, 3};
  int k2h[4] = '{0, 1, 3, 4};
  int k3[4] = '{0, 0, 1, 2};

  mpio_port_io uut (
    .clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .p0_in_i, .p0_out_o, .p0_oe_o, .p1_in_i, .p1_out_o, .p1_oe_o,
    .p2_in_i, .p2_out_o, .p2_oe_o, .p3_in_i, .p3_out_o, .p3_oe_o,
    .p3_pullup_o, .analog_in_sel_o, .pwm_i, .sb_clk_low_i, .sb_dat_low_i,
    .serial_bus_clock_pin_o, .serial_bus_data_pin_o,
    .timer_capture_pin_o, .ext_irq_o
  );
  mpio_pad_model #(.W(8)) u_pad0 (.oe_i(p0_oe_o), .out_i(p0_out_o),
    .ext_i(ext0), .pad_o(p0_in_i));
  mpio_pad_model #(.W(3)) u_pad1 (.oe_i(p1_oe_o), .out_i(p1_out_o),
    .ext_i(ext1), .pad_o(p1_in_i));
  mpio_pad_model #(.W(8)) u_pad2 (.oe_i(p2_oe_o), .out_i(p2_out_o),
    .ext_i(ext2), .pad_o(p2_in_i));
  mpio_pad_model #(.W(8)) u_pad3 (.oe_i(p3_oe_o), .out_i(p3_out_o),
    .ext_i(ext3), .pad_o(p3_in_i));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] t;
    t = x ^ (x << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // kind: 0 in, 1 pp, 2 od, 3 pwm pp, 4 pwm od; gives {oe, out & oe}
  function automatic logic [15:0] drv(input int k, input logic [7:0] dv,
                                      input logic [7:0] pw);
    case (k)
      1: return {8'hff, dv};
      2: return {~dv, 8'h00};
      3: return {8'hff, pw};
      4: return {~pw, 8'h00};
      default: return 16'h0000;
    endcase
  endfunction

  task automatic chk(input string n, input logic [15:0] ex, sn);
    comparisons++;
    if (sn !== ex) begin
      failures++;
      $display("Error %s expected %h seen %h", n, ex, sn);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= dv;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] rv);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    rv = rdata_o;
  endtask

  task automatic irq_chk(input logic [7:0] er, input logic [2:0] eq);
    repeat (3) @(posedge clk_sys_i);
    rd(`MPIO_OFS_IRQ, v);
    chk("irq reg", {8'h00, er}, {8'h00, v});
    chk("irq lines", {13'h0000, eq}, {13'h0000, ext_irq_o});
  endtask

  task automatic conclude;
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial forever #12.5 clk_sys_i = ~clk_sys_i;

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    failures++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int a = 228; a < 236; a++) begin
      rd(8'(a), v);
      chk("reset reg", 16'h0000, {8'h00, v});
    end
    chk("reset pins", 16'h0003, {14'h0000, serial_bus_clock_pin_o,
        serial_bus_data_pin_o});
    // random config readback, unmapped place
    for (int i = 0; i < 14; i++) begin
      seed = xs(seed);
      wr(8'he4 + 8'(seed[10:8] % 3'h7), seed[7:0]);
      rd(8'he4 + 8'(seed[10:8] % 3'h7), v);
      chk("cfg read", {8'h00, seed[7:0]}, {8'h00, v});
    end
    wr(8'h10, 8'h5a);
    rd(8'h10, v);
    chk("unmapped", 16'h0000, {8'h00, v});
    // every field code on ports 1 to 3
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys_i);
      seed = xs(seed);
      d = seed[7:0];
      pwm_i <= seed[14:8];
      ext1 <= seed[18:16];
      ext3 <= seed[31:24];
      sb_dat_low_i <= seed[20];
      sb_clk_low_i <= seed[21];
      cf = {4{c[1:0]}};
      for (int i = 1; i < 4; i++) wr(8'he0 + 8'(i), d);
      for (int i = 6; i < 11; i++) wr(8'he0 + 8'(i), cf);
      if (c == 3) e = {6'h00, sb_clk_low_i, sb_dat_low_i, 8'h00};
      else e = drv(k1[c], d, 8'h00) & 16'h0707;
      s = {5'h00, p1_oe_o, 5'h00, p1_out_o & p1_oe_o};
      chk("p1 pins", e, s & 16'h0707);
      e = {15'h0000, c == 3 ? ext1[0] & ~sb_dat_low_i : 1'b1};
      chk("sb data", e, {15'h0000, serial_bus_data_pin_o});
      e = drv(k2l[c], d, {1'b0, pwm_i}) & 16'h0f0f;
      e = e | (drv(k2h[c], d, {1'b0, pwm_i}) & 16'h7070);
      if (c == 1) e = e | {8'h80, d & 8'h80};
      s = {p2_oe_o, p2_out_o & p2_oe_o};
      chk("p2 pins", e, s);
      s = {p3_oe_o, p3_out_o & p3_oe_o};
      chk("p3 pins", drv(k3[c], d, 8'h00), s);
      e = (c == 1) ? 16'h00ff : 16'h0000;
      chk("p3 pull", e, {8'h00, p3_pullup_o, analog_in_sel_o});
      rd(`MPIO_OFS_P3_DATA, v);
      e = {8'h00, c == 2 ? d : (c == 3 ? d & ext3 : ext3)};
      m = (c == 1) ? 8'hf0 : 8'hff;
      chk("p3 read", e & {8'h00, m}, {8'h00, v & m});
      rd(`MPIO_OFS_P1_DATA, v);
      if (c == 1) chk("p1 read", {13'h0000, d[2:0]}, {8'h00, v});
    end
    // edge interrupts: line 0 rising, line 1 falling, line 2 off
    wr(`MPIO_OFS_P0_LCFG, 8'h09);
    @(posedge clk_sys_i);
    ext0 <= 8'h02;
    wr(`MPIO_OFS_IRQ, 8'h03);
    @(posedge clk_sys_i);
    ext0 <= 8'h03;
    irq_chk(8'h13, 3'h1);
    wr(`MPIO_OFS_IRQ, 8'h13);
    irq_chk(8'h13, 3'h1);
    @(posedge clk_sys_i);
    ext0 <= 8'h05;
    irq_chk(8'h33, 3'h3);
    wr(`MPIO_OFS_IRQ, 8'h23);
    irq_chk(8'h23, 3'h2);
    wr(`MPIO_OFS_IRQ, 8'h21);
    irq_chk(8'h21, 3'h0);
    // capture routing, port 0 drive and readback
    wr(`MPIO_OFS_P0_DATA, 8'hcd);
    wr(`MPIO_OFS_P0_LCFG, 8'hc9);
    @(posedge clk_sys_i);
    ext0 <= 8'h10;
    wr(`MPIO_OFS_P0_HCFG, 8'ha9);
    s = {8'h00, p0_oe_o[7:5], 4'h0, timer_capture_pin_o};
    chk("capture", 16'h00e1, s);
    chk("p0 pins", 16'he8c8, {p0_oe_o, p0_out_o});
    rd(`MPIO_OFS_P0_DATA, v);
    chk("p0 read", 16'h00d8, {8'h00, v});
    conclude();
  end
endmodule
